// ===== mblc_exec.sv
// Execute unit for bit set, AND, bit test skips, accumulator clear, call and watchdog kick.
`include "mblc_defs.svh"
module mblc_exec #(
  parameter int ADDR_W = 5,
  parameter int DATA_W = 8,
  parameter int PC_W   = 11
) (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                op_valid,
  input  mblc_pkg::mblc_op_type    op_code,
  input  wire logic [ADDR_W-1:0]   file_addr,
  input  wire logic [2:0]          bit_sel,
  input  wire logic                dest_bit,
  input  wire logic [7:0]          literal,
  input  wire logic [1:0]          page_bits,
  input  wire logic                prescaler_on_wdt,
  input  wire logic                wdt_tick,
  input  wire logic                expiry_clear,
  input  wire logic                sleep_clear,
  input  wire logic                load_en,
  input  wire logic [ADDR_W-1:0]   load_addr,
  input  wire logic [DATA_W-1:0]   load_data,
  output logic                     op_taken,
  output logic                     instr_done,
  output logic                     idle_cycle,
  output logic [DATA_W-1:0]        acc,
  output logic                     null_flag,
  output logic [PC_W-1:0]          program_counter,
  output logic                     stack_push,
  output logic [PC_W-1:0]          stack_data,
  output logic [7:0]               watchdog_counter,
  output logic                     prescaler_clear,
  output logic                     watchdog_expiry_flag,
  output logic                     sleep_entry_flag
);
  logic [`MBLC_PHASE_W-1:0] phase_reg, phase_next;
  mblc_pkg::mblc_cycle_type cyc_reg, cyc_next;
  mblc_pkg::mblc_op_type    op_reg, op_next;
  logic [ADDR_W-1:0]        addr_reg, addr_next;
  logic [2:0]               bit_reg, bit_next;
  logic                     dest_reg, dest_next;
  logic [7:0]               lit_reg, lit_next;
  logic [1:0]               page_reg, page_next;
  logic                     pend_idle_reg, pend_idle_next;
  logic                     pend_adv_reg, pend_adv_next;
  logic                     idle_adv_reg, idle_adv_next;
  logic                     taken_reg, taken_next;
  logic                     done_reg, done_next;
  logic                     idle_reg, idle_next;
  logic [DATA_W-1:0]        acc_reg, acc_next;
  logic                     null_reg, null_next;
  logic [PC_W-1:0]          pc_reg, pc_next;
  logic                     push_reg, push_next;
  logic [PC_W-1:0]          push_data_reg, push_data_next;
  logic [7:0]               wdt_reg, wdt_next;
  logic                     pre_clr_reg, pre_clr_next;
  logic                     expiry_reg, expiry_next;
  logic                     sleep_reg, sleep_next;
  logic [DATA_W-1:0]        rd_data;
  logic                     mem_wr_en;
  logic [ADDR_W-1:0]        mem_wr_addr;
  logic [DATA_W-1:0]        mem_wr_data;
  logic                     exec_wr;
  logic [DATA_W-1:0]        exec_wr_data;
  logic [DATA_W-1:0]        and_result;
  logic                     commit;
  logic                     take;

  mblc_file_mem #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_file_mem (
    .clk     (clk),
    .rst_b   (rst_b),
    .rd_addr (addr_reg),
    .rd_data (rd_data),
    .wr_en   (mem_wr_en),
    .wr_addr (mem_wr_addr),
    .wr_data (mem_wr_data)
  );

  // The instruction cycle is four clocks: take in phase 0, read data settle, commit in phase 3.
  always_comb begin
    take       = (phase_reg == `MBLC_PHASE_TAKE);
    commit     = (phase_reg == `MBLC_PHASE_COMMIT);
    and_result = acc_reg & rd_data;
    phase_next = phase_reg + `MBLC_PHASE_W'(1);
    cyc_next   = cyc_reg;
    op_next    = op_reg;
    addr_next  = addr_reg;
    bit_next   = bit_reg;
    dest_next  = dest_reg;
    lit_next   = lit_reg;
    page_next  = page_reg;
    pend_idle_next = pend_idle_reg;
    pend_adv_next  = pend_adv_reg;
    idle_adv_next  = idle_adv_reg;
    taken_next = 1'b0;
    done_next  = 1'b0;
    idle_next  = 1'b0;
    acc_next   = acc_reg;
    null_next  = null_reg;
    pc_next    = pc_reg;
    push_next  = 1'b0;
    push_data_next = push_data_reg;
    wdt_next   = wdt_tick ? wdt_reg + 8'h01 : wdt_reg;
    pre_clr_next = 1'b0;
    expiry_next  = expiry_clear ? 1'b0 : expiry_reg;
    sleep_next   = sleep_clear ? 1'b0 : sleep_reg;
    exec_wr      = 1'b0;
    exec_wr_data = rd_data;
    if (take) begin
      if (pend_idle_reg) begin
        // The prefetched instruction is dropped; an idle cycle runs in its place.
        cyc_next       = mblc_pkg::MBLC_CYC_IDLE;
        idle_adv_next  = pend_adv_reg;
        pend_idle_next = 1'b0;
      end else if (op_valid) begin
        cyc_next   = mblc_pkg::MBLC_CYC_EXEC;
        op_next    = op_code;
        addr_next  = file_addr;
        bit_next   = bit_sel;
        dest_next  = dest_bit;
        lit_next   = literal;
        page_next  = page_bits;
        taken_next = 1'b1;
      end else begin
        cyc_next = mblc_pkg::MBLC_CYC_NONE;
      end
    end
    if (commit) begin
      unique case (cyc_reg)
        mblc_pkg::MBLC_CYC_NONE: begin
        end
        mblc_pkg::MBLC_CYC_IDLE: begin
          done_next = 1'b1;
          idle_next = 1'b1;
          if (idle_adv_reg) begin
            pc_next = pc_reg + PC_W'(1);
          end
        end
        mblc_pkg::MBLC_CYC_EXEC: begin
          done_next = 1'b1;
          pc_next   = pc_reg + PC_W'(1);
          case (op_reg)
            mblc_pkg::MBLC_OP_BIT_SET: begin
              exec_wr      = 1'b1;
              exec_wr_data = rd_data | (DATA_W'(1) << bit_reg);
            end
            mblc_pkg::MBLC_OP_ACC_AND_FILE: begin
              null_next = (and_result == '0);
              if (dest_reg == `MBLC_DEST_FILE) begin
                exec_wr      = 1'b1;
                exec_wr_data = and_result;
              end else begin
                acc_next = and_result;
              end
            end
            mblc_pkg::MBLC_OP_SKIP_IF_CLEAR: begin
              pend_idle_next = ~rd_data[bit_reg];
              pend_adv_next  = 1'b1;
            end
            mblc_pkg::MBLC_OP_SKIP_IF_SET: begin
              pend_idle_next = rd_data[bit_reg];
              pend_adv_next  = 1'b1;
            end
            mblc_pkg::MBLC_OP_ACC_CLEAR: begin
              acc_next  = `MBLC_ACC_ZERO;
              null_next = 1'b1;
            end
            mblc_pkg::MBLC_OP_CALL: begin
              push_next      = 1'b1;
              push_data_next = pc_reg + PC_W'(1);
              pc_next        = PC_W'({page_reg, `MBLC_PC8_VALUE, lit_reg});
              // The second cycle is idle and leaves the new target in place.
              pend_idle_next = 1'b1;
              pend_adv_next  = 1'b0;
            end
            mblc_pkg::MBLC_OP_WATCHDOG_KICK: begin
              wdt_next     = `MBLC_WDT_ZERO;
              pre_clr_next = prescaler_on_wdt;
              expiry_next  = 1'b1;
              sleep_next   = 1'b1;
            end
            default: begin
            end
          endcase
        end
        default: begin
        end
      endcase
    end
    // A host load only lands when the executing instruction does not write.
    mem_wr_en   = exec_wr | load_en;
    mem_wr_addr = exec_wr ? addr_reg : load_addr;
    mem_wr_data = exec_wr ? exec_wr_data : load_data;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg      <= `MBLC_PHASE_TAKE;
      cyc_reg        <= mblc_pkg::MBLC_CYC_NONE;
      op_reg         <= mblc_pkg::MBLC_OP_BIT_SET;
      addr_reg       <= '0;
      bit_reg        <= 3'h0;
      dest_reg       <= `MBLC_DEST_ACC;
      lit_reg        <= 8'h00;
      page_reg       <= 2'h0;
      pend_idle_reg  <= 1'b0;
      pend_adv_reg   <= 1'b0;
      idle_adv_reg   <= 1'b0;
      taken_reg      <= 1'b0;
      done_reg       <= 1'b0;
      idle_reg       <= 1'b0;
      acc_reg        <= `MBLC_ACC_RST;
      null_reg       <= 1'b0;
      pc_reg         <= `MBLC_PC_RST;
      push_reg       <= 1'b0;
      push_data_reg  <= `MBLC_PC_RST;
      wdt_reg        <= `MBLC_WDT_RST;
      pre_clr_reg    <= 1'b0;
      expiry_reg     <= `MBLC_FLAG_RST;
      sleep_reg      <= `MBLC_FLAG_RST;
    end else begin
      phase_reg      <= phase_next;
      cyc_reg        <= cyc_next;
      op_reg         <= op_next;
      addr_reg       <= addr_next;
      bit_reg        <= bit_next;
      dest_reg       <= dest_next;
      lit_reg        <= lit_next;
      page_reg       <= page_next;
      pend_idle_reg  <= pend_idle_next;
      pend_adv_reg   <= pend_adv_next;
      idle_adv_reg   <= idle_adv_next;
      taken_reg      <= taken_next;
      done_reg       <= done_next;
      idle_reg       <= idle_next;
      acc_reg        <= acc_next;
      null_reg       <= null_next;
      pc_reg         <= pc_next;
      push_reg       <= push_next;
      push_data_reg  <= push_data_next;
      wdt_reg        <= wdt_next;
      pre_clr_reg    <= pre_clr_next;
      expiry_reg     <= expiry_next;
      sleep_reg      <= sleep_next;
    end
  end

  assign op_taken             = taken_reg;
  assign instr_done           = done_reg;
  assign idle_cycle           = idle_reg;
  assign acc                  = acc_reg;
  assign null_flag            = null_reg;
  assign program_counter      = pc_reg;
  assign stack_push           = push_reg;
  assign stack_data           = push_data_reg;
  assign watchdog_counter     = wdt_reg;
  assign prescaler_clear      = pre_clr_reg;
  assign watchdog_expiry_flag = expiry_reg;
  assign sleep_entry_flag     = sleep_reg;
endmodule : mblc_exec

// ===== mblc_defs.svh
// Constants of the bit, logic and call execute block.
// Functional notes
// - Bit set forces chosen bit of addressed file register high, flags untouched.
// - AND accumulator with file; destination bit picks accumulator or file; null flag only.
// - Skip next instruction when tested bit is zero; flags untouched.
// - Skip next instruction when tested bit is one; flags untouched.
// - A taken skip discards the prefetched instruction and runs an idle cycle instead.
// - Accumulator clear loads zero and sets the null flag.
// - Call pushes current program counter plus one onto the stack.
// - Call loads its 8-bit literal into program counter bits 7 to 0.
// - Call copies status bits 6 and 5 into program counter bits 10 and 9.
// - Call clears program counter bit 8, takes two cycles, flags untouched.
// - Watchdog kick resets the watchdog counter to zero.
// - Watchdog kick clears the prescaler only while it is assigned to the watchdog.
// - Watchdog kick sets both the expiry flag and the sleep entry flag.
`ifndef MBLC_DEFS_SVH
`define MBLC_DEFS_SVH
`define MBLC_PHASES      4
`define MBLC_PHASE_W     2
`define MBLC_PHASE_TAKE  2'h0
`define MBLC_PHASE_COMMIT 2'h3
`define MBLC_PC_RST      11'h000
`define MBLC_ACC_RST     8'h00
`define MBLC_ACC_ZERO    8'h00
`define MBLC_WDT_RST     8'h00
`define MBLC_WDT_ZERO    8'h00
`define MBLC_FLAG_RST    1'b1
`define MBLC_PC8_VALUE   1'b0
`define MBLC_DEST_ACC    1'b0
`define MBLC_DEST_FILE   1'b1
`endif

// ===== mblc_pkg.sv
// Types of the bit, logic and call execute block.
package mblc_pkg;
  typedef enum logic [2:0] {
    MBLC_OP_BIT_SET,
    MBLC_OP_ACC_AND_FILE,
    MBLC_OP_SKIP_IF_CLEAR,
    MBLC_OP_SKIP_IF_SET,
    MBLC_OP_ACC_CLEAR,
    MBLC_OP_CALL,
    MBLC_OP_WATCHDOG_KICK
  } mblc_op_type;

  typedef enum logic [1:0] {
    MBLC_CYC_NONE,
    MBLC_CYC_EXEC,
    MBLC_CYC_IDLE
  } mblc_cycle_type;
endpackage : mblc_pkg

// ===== mblc_file_mem.sv
// File register store with registered read data.
module mblc_file_mem #(
  parameter int ADDR_W = 5,
  parameter int DATA_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : mblc_file_mem

// ===== mblc_exec_props.sv
// Concurrent checks on the execute block outputs.
module mblc_exec_props #(
  parameter int DATA_W = 8,
  parameter int PC_W   = 11
) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              op_taken,
  input wire logic              instr_done,
  input wire logic              idle_cycle,
  input wire logic [DATA_W-1:0] acc,
  input wire logic              null_flag,
  input wire logic [PC_W-1:0]   program_counter,
  input wire logic              stack_push,
  input wire logic [PC_W-1:0]   stack_data,
  input wire logic [7:0]        watchdog_counter,
  input wire logic              prescaler_clear,
  input wire logic              watchdog_expiry_flag,
  input wire logic              sleep_entry_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_idle_end;
    ##4 instr_done && idle_cycle;
  endsequence

  a_taken_done: assert property (op_taken |-> ##[2:3] instr_done)
    else $error("accepted op ended no cycle");
  a_done_gap: assert property (instr_done |=> !instr_done [*3])
    else $error("cycle shorter than four clocks");
  a_push_ret: assert property (stack_push |-> instr_done && !program_counter[8]
    && stack_data == $past(program_counter) + 1'b1) else $error("bad return address");
  a_call_idle: assert property (stack_push |-> s_idle_end)
    else $error("call lacks its idle cycle");
  a_call_hold: assert property (stack_push |=> ($stable(program_counter)
    && $stable(null_flag)) [*4]) else $error("call idle changed state");
  a_idle_pair: assert property (idle_cycle |-> instr_done && $past(instr_done, 4))
    else $error("idle cycle without preceding exec");
  a_kick_zero: assert property ($rose(sleep_entry_flag) |-> instr_done
    && watchdog_counter == 8'h00 && watchdog_expiry_flag) else $error("kick incomplete");
  a_prescale_kick: assert property (prescaler_clear |-> instr_done
    && watchdog_counter == 8'h00 && sleep_entry_flag) else $error("stray prescaler clear");
  a_null_track: assert property ($changed(acc) |-> null_flag == (acc == '0))
    else $error("null flag disagrees with accumulator");
endmodule : mblc_exec_props

bind mblc_exec mblc_exec_props #(.DATA_W(DATA_W), .PC_W(PC_W)) u_props (
  .clk, .rst_b, .op_taken, .instr_done, .idle_cycle, .acc, .null_flag, .program_counter,
  .stack_push, .stack_data, .watchdog_counter, .prescaler_clear, .watchdog_expiry_flag,
  .sleep_entry_flag);

// ===== mblc_exec_test.sv
// Self-checking bench for the bit, logic and call execute block.
module test_mblc_exec;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk = 1'b0;
  logic                  rst_b = 1'b0;
  logic                  op_valid = 1'b0;
  logic                  dest_bit = 1'b0;
  logic                  prescaler_on_wdt = 1'b0;
  logic                  wdt_tick = 1'b0;
  logic                  expiry_clear = 1'b0;
  logic                  sleep_clear = 1'b0;
  logic                  load_en = 1'b0;
  logic [4:0]            file_addr = 5'h00;
  logic [4:0]            load_addr = 5'h00;
  logic [2:0]            bit_sel = 3'h0;
  logic [7:0]            literal = 8'h00;
  logic [7:0]            load_data = 8'h00;
  logic [1:0]            page_bits = 2'h0;
  mblc_pkg::mblc_op_type op_code = mblc_pkg::MBLC_OP_BIT_SET;
  logic                  op_taken, instr_done, idle_cycle, null_flag, stack_push;
  logic                  prescaler_clear, watchdog_expiry_flag, sleep_entry_flag;
  logic [7:0]            acc, watchdog_counter;
  logic [10:0]           program_counter, stack_data;
  int                    mem [32];
  int                    m_acc, m_z, m_pc, m_wdt, m_exp, m_slp, ph, kick_pend;
  int                    num_errors, tests_run;
  int                    seed = 32'h359453BB;

  mblc_exec dut_u (
    .clk, .rst_b, .op_valid, .op_code, .file_addr, .bit_sel, .dest_bit, .literal, .page_bits,
    .prescaler_on_wdt, .wdt_tick, .expiry_clear, .sleep_clear, .load_en, .load_addr,
    .load_data, .op_taken, .instr_done, .idle_cycle, .acc, .null_flag, .program_counter,
    .stack_push, .stack_data, .watchdog_counter, .prescaler_clear, .watchdog_expiry_flag,
    .sleep_entry_flag);

  always #25 clk = ~clk;

  always @(posedge clk) begin
    wdt_tick <= 1'($random(seed));
    expiry_clear <= ({$random(seed)} % 8) == 0;
    sleep_clear <= ({$random(seed)} % 8) == 0;
  end

  // Watchdog counter and status flags advance per clock; a kick commits on the fourth edge.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {ph, m_wdt, kick_pend, m_exp, m_slp} = {32'h0, 32'h0, 32'h0, 32'h1, 32'h1};
    end else begin
      m_wdt = (m_wdt + wdt_tick) % 256;
      if (expiry_clear) m_exp = 0;
      if (sleep_clear) m_slp = 0;
      if (ph == 3 && kick_pend == 1) begin
        {m_wdt, kick_pend, m_exp, m_slp} = {32'h0, 32'h0, 32'h1, 32'h1};
      end
      ph = (ph + 1) % 4;
    end
  end

  task automatic chk(input logic [10:0] got, input int exp);
    tests_run++;
    if (got !== 11'(exp)) begin
      num_errors++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // Issues one op so that it is taken on a phase-zero edge; returns at the edge before the next.
  task automatic do_op(input int o, input int a, input int b, input int d, input int k,
                       input int pg);
    int v, r, idl, ret, psc, t;
    v = mem[a];
    psc = {$random(seed)} % 2;
    idl = (o == 5) || (o == 2 && !v[b]) || (o == 3 && v[b]);
    ret = (m_pc + 1) % 2048;
    op_valid <= 1'b1;
    op_code <= mblc_pkg::mblc_op_type'(o);
    file_addr <= 5'(a);
    bit_sel <= 3'(b);
    dest_bit <= d[0];
    literal <= 8'(k);
    page_bits <= 2'(pg);
    prescaler_on_wdt <= psc[0];
    @(posedge clk);
    op_valid <= idl[0];
    op_code <= mblc_pkg::MBLC_OP_ACC_CLEAR;
    m_pc = ret;
    case (o)
      0: mem[a] = v | (1 << b);
      1: begin
        r = m_acc & v;
        m_z = (r == 0);
        if (d[0]) mem[a] = r;
        else m_acc = r;
      end
      4: {m_acc, m_z} = {32'h0, 32'h1};
      5: m_pc = pg * 512 + k;
      6: kick_pend = 1;
      default: ;
    endcase
    t = 0;
    for (int i = 0; i < 11; i++) begin
      @(negedge clk);
      t += op_taken;
      if (i == 3) begin
        chk(instr_done, 1);
        chk(idle_cycle, 0);
        chk(acc, m_acc);
        chk(null_flag, m_z);
        chk(program_counter, m_pc);
        chk(stack_push, o == 5);
        if (o == 5) chk(stack_data, ret);
        chk(prescaler_clear, (o == 6) ? psc : 0);
        chk(watchdog_counter, m_wdt);
        chk(watchdog_expiry_flag, m_exp);
        chk(sleep_entry_flag, m_slp);
        if (idl == 1 && o != 5) m_pc = (m_pc + 1) % 2048;
      end
      if (i == 7 && idl == 1) begin
        chk(idle_cycle, 1);
        chk(instr_done, 1);
        chk(program_counter, m_pc);
        chk(acc, m_acc);
      end
      @(posedge clk);
      if (i == 3) op_valid <= 1'b0;
    end
    chk(11'(t), 1);
  endtask : do_op

  task automatic summarize;
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      mem[i] = {$random(seed)} % 256;
      load_en <= 1'b1;
      load_addr <= 5'(i);
      load_data <= 8'(mem[i]);
      @(posedge clk);
    end
    load_en <= 1'b0;
    do_op(5, 0, 0, 0, 255, 3);
    do_op(0, 31, 7, 0, 0, 0);
    do_op(3, 31, 7, 0, 0, 0);
    do_op(2, 31, 7, 0, 0, 0);
    do_op(6, 0, 0, 0, 0, 0);
    for (int n = 0; n < 150; n++) begin
      do_op({$random(seed)} % 7, {$random(seed)} % 32, {$random(seed)} % 8,
            {$random(seed)} % 2, {$random(seed)} % 256, {$random(seed)} % 4);
    end
    summarize();
  end

  initial begin
    #300000;
    num_errors++;
    summarize();
  end
endmodule : test_mblc_exec
